// File: eid_edge_detect.sv
// edge detector for five external interrupt inputs with wake-up request
//
// Operation
// [RULE1] input zero: falling edge only when mode bit 0 set, else both edges
// [RULE2] input one: falling edge only when mode bit 1 is set
// [RULE3] input one: both edges when mode bit 1 is clear
// [RULE4] an active edge on input one wakes from power-down
// [RULE5] input two: falling edge only, also wakes from power-down
// [RULE6] input three: falling edge only, also wakes from power-down
// [RULE7] input four: falling edge only, also wakes from power-down
// [RULE8] inputs synchronised first; edge sets pending flag held until cleared
`timescale 1ns/1ps
`default_nettype none
module eid_edge_detect
   import eid_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [eid_pkg::EID_NUM_IN-1:0] i_ext_irq_in,
   input wire logic i_edge_mode_sel0,
   input wire logic i_edge_mode_sel1,
   input wire logic i_power_down,
   input wire logic [eid_pkg::EID_NUM_IN-1:0] i_irq_clear,
   output logic [eid_pkg::EID_NUM_IN-1:0] o_irq_pending,
   output logic o_wake
);
   import eid_pkg::*;

   // ***************************************
   // state and decode signals
   // ***************************************
   logic [EID_NUM_IN-1:0] sync1_reg;
   logic [EID_NUM_IN-1:0] sync1_next;
   logic [EID_NUM_IN-1:0] sync2_reg;
   logic [EID_NUM_IN-1:0] sync2_next;
   logic [EID_NUM_IN-1:0] prev_reg;
   logic [EID_NUM_IN-1:0] prev_next;
   logic [EID_NUM_IN-1:0] fall;
   logic [EID_NUM_IN-1:0] rise;
   logic [EID_NUM_IN-1:0] active_next;
   logic [EID_NUM_IN-1:0] pending_keep;
   logic [EID_NUM_IN-1:0] pending_reg;
   logic [EID_NUM_IN-1:0] pending_next;
   logic wake_reg;
   logic wake_next;

   // ***************************************
   // helper functions
   // ***************************************
   // high before, low now
   function automatic logic [EID_NUM_IN-1:0] eid_fall_vec(
      input logic [EID_NUM_IN-1:0] prev_v,
      input logic [EID_NUM_IN-1:0] cur_v
   );
      eid_fall_vec = prev_v & ~cur_v;
   endfunction

   // low before, high now
   function automatic logic [EID_NUM_IN-1:0] eid_rise_vec(
      input logic [EID_NUM_IN-1:0] prev_v,
      input logic [EID_NUM_IN-1:0] cur_v
   );
      eid_rise_vec = ~prev_v & cur_v;
   endfunction

   // one input with a mode bit: falling only, or both edges
   function automatic logic eid_sel_edge(
      input logic fall_bit,
      input logic rise_bit,
      input logic mode_bit
   );
      logic hit;
      hit = fall_bit; // see [RULE2]
      if (mode_bit != EID_MODE_FALL_ONLY)
      begin
         hit = fall_bit | rise_bit; // see [RULE3]
      end
      eid_sel_edge = hit;
   endfunction

   // any active edge on an input that may wake the device
   function automatic logic eid_wake_hit(
      input logic [EID_NUM_IN-1:0] active_v
   );
      logic [EID_NUM_IN-1:0] masked;
      masked = active_v & EID_WAKE_MASK;
      eid_wake_hit = masked != EID_ZERO5;
   endfunction

   // ***************************************
   // synchroniser chain
   // ***************************************
   // pins idle high, so the chain resets high and no false edge follows reset
   // only the second stage reads the first, never the edge logic
   always_comb
   begin
      sync1_next = i_ext_irq_in; // see [RULE8]
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync1_reg <= EID_IN_RST;
      end
      else
      begin
         sync1_reg <= sync1_next;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync2_reg <= EID_IN_RST;
      end
      else
      begin
         sync2_reg <= sync2_next;
      end
   end

   // edge history, one cycle behind the second stage
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         prev_reg <= EID_IN_RST;
      end
      else
      begin
         prev_reg <= prev_next;
      end
   end

   // ***************************************
   // edge detection
   // ***************************************
   always_comb
   begin
      fall = eid_fall_vec(prev_reg, sync2_reg);
      rise = eid_rise_vec(prev_reg, sync2_reg);
   end

   // ***************************************
   // edge selection
   // ***************************************
   always_comb
   begin
      active_next = fall;
      // input zero: mode bit picks falling only or both edges
      active_next[EID_IDX_IN0] = eid_sel_edge(
         fall[EID_IDX_IN0],
         rise[EID_IDX_IN0],
         i_edge_mode_sel0
      ); // see [RULE1]
      // input one: same choice through its own mode bit
      active_next[EID_IDX_IN1] = eid_sel_edge(
         fall[EID_IDX_IN1],
         rise[EID_IDX_IN1],
         i_edge_mode_sel1
      ); // see [RULE2] see [RULE3]
      // inputs two to four have no mode, falling edges only
      active_next[EID_IDX_IN2] = fall[EID_IDX_IN2]; // see [RULE5]
      active_next[EID_IDX_IN3] = fall[EID_IDX_IN3]; // see [RULE6]
      active_next[EID_IDX_IN4] = fall[EID_IDX_IN4]; // see [RULE7]
   end

   // ***************************************
   // pending flags
   // ***************************************
   // set wins over clear, so an edge in the clearing cycle is never lost
   always_comb
   begin
      pending_keep = pending_reg & ~i_irq_clear;
      pending_next = pending_keep | active_next; // see [RULE8]
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pending_reg <= EID_ZERO5;
      end
      else
      begin
         pending_reg <= pending_next;
      end
   end

   // ***************************************
   // power-down wake
   // ***************************************
   // a one-cycle pulse; input zero never wakes the device
   always_comb
   begin
      wake_next = i_power_down && eid_wake_hit(active_next); // see [RULE4] see [RULE5]
      // inputs three and four share the mask, see [RULE6] see [RULE7]
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wake_reg <= 1'h0;
      end
      else
      begin
         wake_reg <= wake_next;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   assign o_irq_pending = pending_reg;
   assign o_wake = wake_reg;
endmodule
`default_nettype wire

// File: eid_pkg.sv
// package of constants for the external interrupt edge detector
package eid_pkg;
   localparam int unsigned EID_NUM_IN = 5;
   localparam int unsigned EID_SYNC_STAGES = 2;
   localparam logic [4:0] EID_IN_RST = 5'h1F;
   localparam logic [4:0] EID_ZERO5 = 5'h00;
   localparam logic EID_MODE_FALL_ONLY = 1'b1;
   localparam int unsigned EID_IDX_IN0 = 0;
   localparam int unsigned EID_IDX_IN1 = 1;
   localparam int unsigned EID_IDX_IN2 = 2;
   localparam int unsigned EID_IDX_IN3 = 3;
   localparam int unsigned EID_IDX_IN4 = 4;
   localparam logic [4:0] EID_WAKE_MASK = 5'h1E;
endpackage

// File: eid_checker.sv
// port checker for the edge detector
`timescale 1ns/1ps
`default_nettype none
module eid_checker
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_ext_irq_in,
   input wire logic i_edge_mode_sel0,
   input wire logic i_edge_mode_sel1,
   input wire logic i_power_down,
   input wire logic [4:0] i_irq_clear,
   input wire logic [4:0] o_irq_pending,
   input wire logic o_wake
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   for (genvar i = 0; i < 5; i++)
   begin : g_bit
      a_fall_sets: assert property
         ($fell(i_ext_irq_in[i]) |-> ##[2:4] o_irq_pending[i]) else $error("edge lost");
      a_set_has_edge: assert property
         ($rose(o_irq_pending[i]) |-> $past(i_ext_irq_in[i], 3) != $past(i_ext_irq_in[i], 4))
         else $error("pending set without edge");
      a_clear_drops: assert property
         ($past(i_irq_clear[i]) && o_irq_pending[i]
            |-> $past(i_ext_irq_in[i], 3) != $past(i_ext_irq_in[i], 4))
         else $error("pending kept after clear");
   end
   for (genvar k = 2; k < 5; k++)
   begin : g_fall
      a_fall_only: assert property
         ($rose(o_irq_pending[k]) |-> $past(i_ext_irq_in[k], 4) && !$past(i_ext_irq_in[k], 3))
         else $error("pending set without falling edge");
   end
   a_in0_both: assert property
      ($rose(i_ext_irq_in[0]) && !i_edge_mode_sel0 |-> ##3 o_irq_pending[0])
      else $error("rising edge lost on input zero");
   a_in1_both: assert property
      ($rose(i_ext_irq_in[1]) && !i_edge_mode_sel1 |-> ##3 o_irq_pending[1])
      else $error("rising edge lost on input one");
   a_wake_gated: assert property (o_wake |-> $past(i_power_down)) else $error("wake");
   a_pend_hold: assert property
      (($past(o_irq_pending & ~i_irq_clear) & ~o_irq_pending) == 5'h0) else $error("hold");
   cover property (o_wake);
   cover property ($rose(o_irq_pending[0]));
   cover property ($fell(o_irq_pending[4]));
endmodule
bind eid_edge_detect eid_checker u_chk (.*);
`default_nettype wire

// File: eid_pin_model.sv
// model of the circuits that drive the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module eid_pin_model(input wire logic i_ref_clk, input wire logic [4:0] i_level,
   output logic [4:0] o_pin = 5'h1F);
   always @(posedge i_ref_clk) o_pin <= i_level;
endmodule
`default_nettype wire

// File: test_external_interrupt_edge_detect.sv
// self-checking test of the edge detector
`timescale 1ns/1ps
`default_nettype none
module test_external_interrupt_edge_detect;
   logic clk = 0, rst_n = 0, s0 = 0, s1 = 0, pd = 0, wk, wo;
   logic [4:0] lv = 5'h1F, pin, clr = 5'h0, pend, e;
   int errors = 0, check_count = 0, r;
   always #4 clk = ~clk;
   always @(posedge clk) wo <= clr[0] ? 1'b0 : wo | wk;
   eid_pin_model pm_u (.i_ref_clk(clk), .i_level(lv), .o_pin(pin));
   eid_edge_detect dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ext_irq_in(pin), .o_wake(wk),
      .i_edge_mode_sel0(s0), .i_edge_mode_sel1(s1), .i_power_down(pd), .i_irq_clear(clr),
      .o_irq_pending(pend));
   task cmp(string n, logic [4:0] x, g);
      check_count++;
      errors += int'(x !== g);
      if (x !== g) $display("[FAIL] %s expected %h seen %h", n, x, g);
   endtask
   task cmp_wake(string n, logic x, g);
      check_count++;
      errors += int'(x !== g);
      if (x !== g) $display("[FAIL] %s expected %h seen %h", n, x, g);
   endtask
   task results(int late);
      errors += late;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task step(int i);
      r = i < 4 ? {i[1], i[1], 1'b1, {5{i[0]}}} : $urandom;
      e = lv & ~r[4:0] | {3'h0, ~lv[1:0] & r[1:0] & ~{r[6], r[5]}};
      @(posedge clk) {lv, s0, s1, pd, clr} <= {r[4:0], r[5], r[6], r[7], 5'h1F};
      @(posedge clk) clr <= 5'h0;
      repeat (6) @(posedge clk);
      cmp("pending01", {3'h0, e[1:0]}, {3'h0, pend[1:0]});
      cmp("pending24", {e[4:2], 2'h0}, {pend[4:2], 2'h0});
      cmp("pending", e, pend);
      cmp_wake("wake", r[7] & |e[4:1], wo);
   endtask
   initial
   begin
      void'($urandom(23));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 44; i++) step(i);
      results(0);
   end
   initial #9000 results(1);
endmodule
`default_nettype wire
